// ---- verilog/ara_pkg.sv ----
// Shared constants for the register access and sync link: map, opcodes, timing.
// Assumes a 25 MHz system clock and 16-bit link words.
package ara_pkg;
    typedef logic [15:0] ara_word_t;
    typedef logic [5:0]  ara_addr_t;

    // ==========================================================
    // Register map
    localparam ara_addr_t ADDR_ID       = 6'h00;
    localparam ara_addr_t ADDR_STATUS   = 6'h01;
    localparam ara_addr_t ADDR_MODE     = 6'h02;
    localparam ara_addr_t ADDR_CLOCK    = 6'h03;
    localparam ara_addr_t ADDR_GAIN_LO  = 6'h04;
    localparam ara_addr_t ADDR_GAIN_HI  = 6'h05;
    localparam ara_addr_t ADDR_CFG      = 6'h06;

    localparam ara_word_t STATUS_RST    = 16'h0500;
    localparam ara_word_t MODE_RST      = 16'h0510;
    localparam ara_word_t CLOCK_RST     = 16'h7f0e;
    localparam ara_word_t GAIN_LO_RST   = 16'h0000;
    localparam ara_word_t GAIN_HI_RST   = 16'h0000;
    localparam ara_word_t CFG_RST       = 16'h0600;

    // Identity family nibble: arbitrary value
    localparam logic [3:0] ID_FAMILY     = 4'h3;
    localparam logic [3:0] ID_CHAN_COUNT = 4'h6;

    // Field positions
    localparam int unsigned MODE_RX_CRC_EN  = 12;
    localparam int unsigned MODE_CRC_TYPE   = 11;
    localparam int unsigned MODE_RESET_FLAG = 10;
    localparam int unsigned MODE_WLEN_LSB   = 8;
    localparam int unsigned CFG_GC_EN       = 8;
    localparam int unsigned CLOCK_CH_EN_LSB = 8;

    // ==========================================================
    // Commands and responses
    localparam logic [2:0] OP_READ      = 3'b101;
    localparam logic [2:0] OP_WRITE     = 3'b011;
    localparam logic [2:0] OP_WRITE_ACK = 3'b010;
    localparam logic [2:0] OP_MULTI_HDR = 3'b111;
    localparam ara_word_t  CMD_RESET        = 16'h0011;
    localparam ara_word_t  RESP_RESET_DONE  = 16'hff26;
    localparam ara_word_t  RESP_RESET_SHORT = 16'h0011;
    localparam ara_word_t  CRC_INIT         = 16'hffff;
    localparam ara_word_t  CRC_POLY         = 16'h1021;
    localparam logic [7:0] FRAME_WORDS      = 8'h08;
    localparam logic [7:0] CH_WORDS         = 8'h06;

    // ==========================================================
    // Timing
    localparam int unsigned SYS_CLK_KHZ     = 25000;
    localparam int unsigned DATA_RATE_NS    = 10240;
    localparam logic [8:0]  DR_LAST         = 9'(DATA_RATE_NS * SYS_CLK_KHZ / 1000000 - 1);
    localparam logic [1:0]  SETTLE_CONVS    = 2'd3;
    localparam int unsigned SYNC_LOW_NS     = 160;
    localparam logic [7:0]  SYNC_LOW_CYCLES = 8'((SYNC_LOW_NS * SYS_CLK_KHZ + 999999) / 1000000);
    localparam int unsigned RST_LOW_MIN_NS  = 2000;
    localparam logic [7:0]  RST_LOW_MIN_CYCLES = 8'((RST_LOW_MIN_NS * SYS_CLK_KHZ + 999999) / 1000000);
    localparam logic [2:0]  SCLK_HALF_LAST  = 3'd3;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_LOW  = 3'b010,
        H_HIGH = 3'b100
    } ara_hstate_t;
endpackage : ara_pkg

// ---- verilog/ara_link_if.sv ----
// Serial link between host and device: clock, frame select, data, sync pin.
// Host drives every line but the device data output.
`timescale 1ns/100ps
interface ara_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic sync_n;

    modport dev  (input sclk, input cs_n, input din, input sync_n, output dout);
    modport host (output sclk, output cs_n, output din, output sync_n, input dout);
endinterface : ara_link_if

// ---- verilog/ara_device.sv ----
// Device end: command interpreter on the link clock, sync logic on the master clock.
// Assumes the host makes the link clock and holds cs_n high between frames.
// Operation
// - Response goes out in the next frame
// - Single read answers with register contents
// - Multi read spans words; host keeps clocking
// - Multi read answer frame drops conversion words
// - Write command: 011, address, count minus one
// - Host sends one data word per register
// - Host appends checksum word when enabled
// - Each register commits as soon as shifted
// - Checksum mismatch sets status error flag
// - Read-only or unmapped writes are discarded
// - Gaps count but stay unchanged; the write count here includes only committed registers
// - Write answer: 010, address, written minus one
// - Host lengthens frame for all conversion words
// - Short frames only with channels disabled
// - Host reads every output word per period
// - Reset command needs a full frame
// - Sync pulse between one clock and reset width
// - Misaligned sync falling edge resets filters
// - Compare against zero-phase data rate clock
// - Global chop restarts on any sync toggle
// - Phase settings kept through sync
// - Results unsettled for three conversions after sync
// - Read command: 101, address, count minus one
// - Multi read header 111 echoes address, count
`timescale 1ns/100ps
module ara_device
(
    input  wire logic  sys_clk,
    input  wire logic  nrst,
    input  wire logic  clk_en,
    ara_link_if.dev    link,
    output logic       sample_ready_pin_n,
    output logic       data_settled,
    output logic       filter_restart
);
    import ara_pkg::*;

    // ==========================================================
    // Link domain declarations
    logic [3:0]  bit_idx;
    logic [7:0]  word_idx;
    ara_word_t   rx_sh;
    ara_word_t   tx_sh;
    ara_word_t   crc;
    ara_word_t   crc_hold;
    ara_word_t   mode_r;
    ara_word_t   clock_r;
    ara_word_t   gain_lo;
    ara_word_t   gain_hi;
    ara_word_t   cfg_r;
    ara_word_t   cmd_r;
    ara_word_t   nxt_resp;
    logic        crc_err;
    logic        f_resync;
    logic        nxt_multi;
    logic        cur_multi;
    ara_addr_t   nxt_addr;
    ara_addr_t   cur_addr;
    logic [6:0]  nxt_n;
    logic [6:0]  cur_n;
    logic        wr_act;
    ara_addr_t   wr_addr;
    logic [6:0]  wr_n;
    logic [7:0]  wr_cnt;
    logic        rs_meta;
    logic        rs_sync;
    logic        rs_prev;
    logic        rs_tog;

    // ==========================================================
    // Link domain decode
    wire         frame_rst_n = nrst & ~link.cs_n;
    wire         word_end    = (bit_idx == 4'hf);
    wire         first_bit   = (bit_idx == 4'h0) && (word_idx == 8'h00);
    ara_word_t   rx_word;
    ara_word_t   crc_base;
    ara_word_t   crc_next;
    assign rx_word  = {rx_sh[14:0], link.din};
    assign crc_base = first_bit ? CRC_INIT : crc;
    assign crc_next = {crc_base[14:0], 1'b0} ^ ((crc_base[15] ^ link.din) ? CRC_POLY : 16'h0000);

    wire [2:0]   cmd_op   = rx_word[15:13];
    wire [5:0]   cmd_addr = rx_word[12:7];
    wire [6:0]   cmd_n    = rx_word[6:0];
    wire [7:0]   data_idx = 8'(word_idx - 8'd1);
    wire         in_data  = wr_act && (word_idx != 8'h00) && (data_idx <= {1'b0, wr_n});
    wire         crc_word = wr_act && mode_r[MODE_RX_CRC_EN] && (data_idx == 8'({1'b0, wr_n} + 8'd1));
    wire [7:0]   wr_tgt   = 8'({2'b00, wr_addr} + data_idx);
    wire         wr_ok    = in_data && (wr_tgt >= {2'b00, ADDR_MODE}) && (wr_tgt <= {2'b00, ADDR_CFG});
    wire [7:0]   wr_cnt_n = 8'(wr_cnt + 8'd1);
    wire         is_null  = (cmd_op != OP_READ) && (cmd_op != OP_WRITE) && (rx_word != CMD_RESET);
    wire         rs_event = rs_sync ^ rs_prev;
    wire         full_end = word_end && (word_idx == 8'(FRAME_WORDS - 8'd1));

    ara_word_t   status_word;
    assign status_word = {1'b0, f_resync, 1'b0, crc_err, mode_r[MODE_CRC_TYPE], mode_r[MODE_RESET_FLAG],
                          mode_r[MODE_WLEN_LSB+1 -: 2], 8'h00};

    function automatic ara_word_t reg_rd(input logic [7:0] a);
        ara_word_t v;
        v = 16'h0000;
        if (a == {2'b00, ADDR_ID})           v = {ID_FAMILY, ID_CHAN_COUNT, 8'h00};
        else if (a == {2'b00, ADDR_STATUS})  v = status_word;
        else if (a == {2'b00, ADDR_MODE})    v = mode_r;
        else if (a == {2'b00, ADDR_CLOCK})   v = clock_r;
        else if (a == {2'b00, ADDR_GAIN_LO}) v = gain_lo;
        else if (a == {2'b00, ADDR_GAIN_HI}) v = gain_hi;
        else if (a == {2'b00, ADDR_CFG})     v = cfg_r;
        return v;
    endfunction : reg_rd

    // Word to send: response, then multi-read data or conversion slots
    wire [7:0]   rd_addr  = 8'({2'b00, cur_addr} + data_idx);
    wire         rd_slot  = cur_multi && (data_idx <= {1'b0, cur_n});
    ara_word_t   tx_word;
    assign tx_word = (word_idx == 8'h00) ? nxt_resp :
                     rd_slot ? reg_rd(rd_addr) :
                     16'h0000;

    // ==========================================================
    // Link domain: bit and word counters, cleared between frames
    always_ff @(posedge link.sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            bit_idx  <= 4'h0;
            word_idx <= 8'h00;
        end
        else
        begin
            bit_idx <= 4'(bit_idx + 4'h1);
            if (word_end && word_idx != 8'hff)
                word_idx <= 8'(word_idx + 8'h1);
        end
    end

    // ==========================================================
    // Link domain: shifters, checksum, response framing
    always_ff @(posedge link.sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_sh     <= 16'h0000;
            tx_sh     <= 16'h0000;
            link.dout <= 1'b0;
            crc       <= 16'h0000;
            crc_hold  <= 16'h0000;
            cur_multi <= 1'b0;
            cur_addr  <= 6'h00;
            cur_n     <= 7'h00;
        end
        else
        begin
            rx_sh <= rx_word;
            crc   <= crc_next;
            if (bit_idx == 4'h0)
            begin
                link.dout <= tx_word[15];
                tx_sh     <= {tx_word[14:0], 1'b0};
            end
            else
            begin
                link.dout <= tx_sh[15];
                tx_sh     <= {tx_sh[14:0], 1'b0};
            end
            if (first_bit)
            begin
                cur_multi <= nxt_multi;
                cur_addr  <= nxt_addr;
                cur_n     <= nxt_n;
            end
            if (word_end && in_data)
                crc_hold <= crc_next;
        end
    end

    // ==========================================================
    // Link domain: resync event from the master clock side
    always_ff @(posedge link.sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rs_meta <= 1'b0;
            rs_sync <= 1'b0;
            rs_prev <= 1'b0;
        end
        else
        begin
            rs_meta <= rs_tog;
            rs_sync <= rs_meta;
            rs_prev <= rs_sync;
        end
    end

    // ==========================================================
    // Link domain: command decode and register file
    always_ff @(posedge link.sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_r <= MODE_RST;
            clock_r <= CLOCK_RST;
            gain_lo <= GAIN_LO_RST;
            gain_hi <= GAIN_HI_RST;
            cfg_r <= CFG_RST;
            cmd_r <= 16'h0000;
            nxt_resp <= STATUS_RST;
            crc_err <= 1'b0;
            f_resync <= 1'b0;
            nxt_multi <= 1'b0;
            nxt_addr <= 6'h00;
            nxt_n <= 7'h00;
            wr_act <= 1'b0;
            wr_addr <= 6'h00;
            wr_n <= 7'h00;
            wr_cnt <= 8'h00;
        end
        else
        begin
            // Sticky flags: a set in the same edge as a clear wins
            crc_err  <= (word_end && crc_word && rx_word != crc_hold) ||
                        (crc_err && !(word_end && word_idx == 8'h00 && is_null));
            f_resync <= rs_event || (f_resync && !(word_end && word_idx == 8'h00 && is_null));
            if (word_end && word_idx == 8'h00)
            begin
                cmd_r     <= rx_word;
                nxt_multi <= 1'b0;
                wr_act    <= 1'b0;
                if (cmd_op == OP_READ)
                begin
                    nxt_multi <= (cmd_n != 7'h00);
                    nxt_addr  <= cmd_addr;
                    nxt_n     <= cmd_n;
                    nxt_resp  <= (cmd_n == 7'h00) ? reg_rd({2'b00, cmd_addr})
                                                 : {OP_MULTI_HDR, cmd_addr, cmd_n};
                end
                else if (cmd_op == OP_WRITE)
                begin
                    wr_act   <= 1'b1;
                    wr_addr  <= cmd_addr;
                    wr_n     <= cmd_n;
                    wr_cnt   <= 8'h00;
                    nxt_resp <= {OP_WRITE_ACK, cmd_addr, 7'h7f};
                end
                else if (rx_word == CMD_RESET)
                    nxt_resp <= RESP_RESET_SHORT;
                else
                    nxt_resp <= status_word;
            end
            else if (word_end && wr_ok)
            begin
                unique case (wr_tgt[5:0])
                    ADDR_MODE:    mode_r  <= rx_word;
                    ADDR_CLOCK:   clock_r <= rx_word;
                    ADDR_GAIN_LO: gain_lo <= rx_word;
                    ADDR_GAIN_HI: gain_hi <= rx_word;
                    default:      cfg_r   <= rx_word;
                endcase
                wr_cnt   <= wr_cnt_n;
                nxt_resp <= {OP_WRITE_ACK, wr_addr, 7'(wr_cnt_n - 8'd1)};
            end
            if (full_end && cmd_r == CMD_RESET)
            begin
                mode_r   <= MODE_RST;
                clock_r  <= CLOCK_RST;
                gain_lo  <= GAIN_LO_RST;
                gain_hi  <= GAIN_HI_RST;
                cfg_r    <= CFG_RST;
                nxt_resp <= RESP_RESET_DONE;
            end
        end
    end

    // ==========================================================
    // Master clock domain: sync pin, data rate clock, filter restart
    logic        sy_meta;
    logic        sy_sync;
    logic        sy_prev;
    logic        gc_meta;
    logic        gc_sync;
    logic [8:0]  dr_cnt;
    logic [1:0]  settle;
    wire         sync_fall = sy_prev & ~sy_sync;
    wire         sync_tog  = sy_prev ^ sy_sync;
    wire         dr_tick   = (dr_cnt == DR_LAST);
    wire         restart   = (sync_fall && dr_cnt != 9'h000) || (gc_sync && sync_tog);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sy_meta <= 1'b1;
            sy_sync <= 1'b1;
            sy_prev <= 1'b1;
            gc_meta <= 1'b0;
            gc_sync <= 1'b0;
            dr_cnt <= 9'h000;
            settle <= SETTLE_CONVS;
            rs_tog <= 1'b0;
            sample_ready_pin_n <= 1'b1;
            data_settled <= 1'b0;
            filter_restart <= 1'b0;
        end
        else if (clk_en)
        begin
            sy_meta <= link.sync_n;
            sy_sync <= sy_meta;
            sy_prev <= sy_sync;
            gc_meta <= cfg_r[CFG_GC_EN];
            gc_sync <= gc_meta;
            filter_restart <= restart;
            if (restart)
            begin
                dr_cnt <= 9'h000;
                settle <= SETTLE_CONVS;
                rs_tog <= ~rs_tog;
            end
            else
            begin
                dr_cnt <= dr_tick ? 9'h000 : 9'(dr_cnt + 9'h001);
                if (dr_tick && settle != 2'd0)
                    settle <= 2'(settle - 2'd1);
            end
            sample_ready_pin_n <= ~(dr_tick && !restart);
            data_settled <= (settle == 2'd0) && !restart;
        end
    end
endmodule : ara_device

// ---- verilog/ara_host.sv ----
// Host end: frames words on the link from a word-by-word user port, pulses sync.
// Assumes the user presents tx_word for the index shown on next_word_idx.
`timescale 1ns/100ps
module ara_host
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    ara_link_if.host         link,
    input  wire logic        frame_start,
    input  wire logic [7:0]  frame_words,
    input  wire logic [15:0] tx_word,
    input  wire logic        sync_req,
    output logic             busy,
    output logic [7:0]       next_word_idx,
    output logic             rx_valid,
    output logic [15:0]      rx_word,
    output logic             sync_active
);
    import ara_pkg::*;

    // ==========================================================
    // Declarations
    ara_hstate_t state;
    logic [2:0]  ph;
    logic [3:0]  bitc;
    logic [7:0]  left;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic        do_meta;
    logic        do_sync;
    logic [7:0]  sync_cnt;
    wire  [15:0] rx_next   = {rx_sh[14:0], do_sync};
    wire         half_done = (ph == SCLK_HALF_LAST);

    // ==========================================================
    // Frame engine and sync pulse
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= H_IDLE;
            ph <= 3'd0;
            bitc <= 4'h0;
            left <= 8'h00;
            tx_sh <= 16'h0000;
            rx_sh <= 16'h0000;
            do_meta <= 1'b0;
            do_sync <= 1'b0;
            sync_cnt <= 8'h00;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.din <= 1'b0;
            link.sync_n <= 1'b1;
            busy <= 1'b0;
            next_word_idx <= 8'h00;
            rx_valid <= 1'b0;
            rx_word <= 16'h0000;
            sync_active <= 1'b0;
        end
        else if (clk_en)
        begin
            do_meta  <= link.dout;
            do_sync  <= do_meta;
            rx_valid <= 1'b0;
            if (sync_active)
            begin
                sync_cnt <= 8'(sync_cnt - 8'd1);
                if (sync_cnt == 8'd1)
                begin
                    link.sync_n <= 1'b1;
                    sync_active <= 1'b0;
                end
            end
            else if (sync_req)
            begin
                link.sync_n <= 1'b0;
                sync_active <= 1'b1;
                sync_cnt    <= SYNC_LOW_CYCLES;
            end
            unique case (state)
                H_IDLE:
                begin
                    next_word_idx <= 8'h00;
                    if (frame_start && frame_words != 8'h00)
                    begin
                        link.cs_n <= 1'b0;
                        link.din <= tx_word[15];
                        tx_sh <= tx_word;
                        left <= 8'(frame_words - 8'd1);
                        next_word_idx <= 8'h01;
                        bitc <= 4'h0;
                        ph <= 3'd0;
                        busy <= 1'b1;
                        state <= H_LOW;
                    end
                end
                H_LOW:
                begin
                    ph <= half_done ? 3'd0 : 3'(ph + 3'd1);
                    if (half_done)
                    begin
                        link.sclk <= 1'b1;
                        state <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    ph <= half_done ? 3'd0 : 3'(ph + 3'd1);
                    if (half_done)
                    begin
                        link.sclk <= 1'b0;
                        rx_sh <= rx_next;
                        state <= H_LOW;
                        if (bitc == 4'hf)
                        begin
                            rx_valid <= 1'b1;
                            rx_word <= rx_next;
                            if (left == 8'h00)
                            begin
                                link.cs_n <= 1'b1;
                                busy <= 1'b0;
                                state <= H_IDLE;
                            end
                            else
                            begin
                                tx_sh <= tx_word;
                                link.din <= tx_word[15];
                                left <= 8'(left - 8'd1);
                                next_word_idx <= 8'(next_word_idx + 8'd1);
                                bitc <= 4'h0;
                            end
                        end
                        else
                        begin
                            bitc <= 4'(bitc + 4'h1);
                            tx_sh <= {tx_sh[14:0], 1'b0};
                            link.din <= tx_sh[14];
                        end
                    end
                end
            endcase
        end
    end
endmodule : ara_host

// ---- tb/ara_chk.sv ----
// Checker for the link lines and the sync outputs between host and device.
// Assumes every line is sampled on the system clock.
`timescale 1ns/100ps
module ara_chk
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic sync_n,
    input wire logic sample_ready_pin_n,
    input wire logic data_settled,
    input wire logic filter_restart
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ==========================
    // Framing and sync
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("sclk outside frame");
    frame_lead_a: assert property ($fell(cs_n) |-> !sclk[*4] ##1 sclk)
        else $error("frame lead");
    sclk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("sclk high time");
    din_hold_a: assert property (sclk && $past(sclk) |-> $stable(din))
        else $error("din moved");
    dout_edge_a: assert property (!cs_n && $changed(dout) |-> $rose(sclk))
        else $error("dout moved");
    sync_width_a: assert property ($fell(sync_n) |-> !sync_n[*4] ##1 sync_n)
        else $error("sync width");
    ready_pulse_a: assert property (!sample_ready_pin_n |=> sample_ready_pin_n[*8])
        else $error("ready");
    restart_cause_a: assert property (filter_restart |-> $past(sync_n, 3) != $past(sync_n, 4))
        else $error("restart");
    settle_hold_a: assert property (filter_restart |-> !data_settled[*8])
        else $error("settled");
endmodule : ara_chk

// ---- tb/adc_register_access_and_sync_tb_top.sv ----
// Bench joining host and device ends; frames are built word by word.
// Assumes ara_pkg, the link interface and both ends are compiled first.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module adc_register_access_and_sync_tb_top;
    import ara_pkg::*;
    logic       sys_clk = 0, nrst = 1, frame_start = 0, sync_req = 0;
    logic [7:0] frame_words = 8'h01, next_word_idx;
    logic       busy, rx_valid, sync_active, sample_ready_pin_n, data_settled, filter_restart;
    ara_word_t  tx_word = 16'h0000, rx_word, r0, rx[16], txq[$] = '{16'h0000};
    int         rx_n = 0, bad_count = 0, n_checks = 0;
    ara_link_if link();
    ara_host i_ara_host (.sys_clk, .nrst, .clk_en(1'b1), .link(link.host), .frame_start, .frame_words,
        .tx_word, .sync_req, .busy, .next_word_idx, .rx_valid, .rx_word, .sync_active);
    ara_device i_ara_device (.sys_clk, .nrst, .clk_en(1'b1), .link(link.dev), .sample_ready_pin_n,
        .data_settled, .filter_restart);
    ara_chk i_ara_chk (.sys_clk, .nrst, .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din), .dout(link.dout),
        .sync_n(link.sync_n), .sample_ready_pin_n, .data_settled, .filter_restart);
    always #20 sys_clk = ~sys_clk;
    always @(negedge sys_clk)
    begin
        tx_word <= (busy !== 1'b1) ? txq[0] : (next_word_idx < txq.size()) ? txq[next_word_idx] : 16'h0000;
        if (rx_valid === 1'b1 && rx_n < 16)
        begin
            rx[rx_n] = rx_word;
            rx_n++;
        end
    end
    // ==========================
    // Access tasks
    task frame(input ara_word_t q[$], input int n);
        int wd;
        txq = q;
        rx_n = 0;
        @(negedge sys_clk);
        frame_words = n[7:0];
        frame_start = 1'b1;
        @(negedge sys_clk);
        frame_start = 1'b0;
        for (wd = 0; busy !== 1'b0 && wd < 3000; wd++) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask : frame
    task read_all(input ara_word_t e[7]);
        frame('{16'ha006}, 8);
        r0 = rx[0];
        frame('{16'h0000}, 8);
        `CHK("multi header", 16'he006, rx[0])
        for (int i = 0; i < 7; i++) `CHK("register", e[i], rx[i + 1])
    endtask : read_all
    task pulse_sync(input int lag);
        while (sample_ready_pin_n !== 1'b0) @(negedge sys_clk);
        repeat (lag) @(negedge sys_clk);
        sync_req = 1'b1;
        @(negedge sys_clk);
        sync_req = 1'b0;
        `CHK("sync active", 1'b1, sync_active)
        repeat (20) @(negedge sys_clk);
    endtask : pulse_sync
    task give_verdict;
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial
    begin
        #2000000;
        bad_count++;
        give_verdict();
    end
    // ==========================
    // Scenarios
    initial
    begin
        #1 nrst = 1'b0;
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        frame('{16'h0000}, 8);
        `CHK("first status", STATUS_RST, rx[0])
        read_all('{{ID_FAMILY, ID_CHAN_COUNT, 8'h00}, 16'h0500, 16'h0510, 16'h7f0e, 16'h0000, 16'h0000, 16'h0600});
        frame('{16'h6008, 16'hffff, 16'hffff, 16'h0510, 16'h0000, 16'h3456, 16'h0021, 16'h0600, 16'h5555,
            16'h5555}, 10);
        read_all('{{ID_FAMILY, ID_CHAN_COUNT, 8'h00}, 16'h0500, 16'h0510, 16'h0000, 16'h3456, 16'h0021, 16'h0600});
        `CHK("write answer", 16'h4004, r0)
        frame('{16'h6100, 16'h1510}, 2);
        frame('{16'h6200, 16'h0abc, 16'h0000}, 3);
        frame('{16'ha080}, 1);
        `CHK("crc write answer", 16'h4200, rx[0])
        frame('{16'ha200}, 1);
        `CHK("crc flag", 16'h1500, rx[0])
        frame('{16'h0011}, 1);
        `CHK("stored anyway", 16'h0abc, rx[0])
        frame('{16'ha200}, 1);
        `CHK("short reset", 16'h0011, rx[0])
        frame('{16'h0011}, 8);
        `CHK("kept gain", 16'h0abc, rx[0])
        frame('{16'ha200}, 8);
        `CHK("reset done", 16'hff26, rx[0])
        frame('{16'h0000}, 8);
        `CHK("gain default", 16'h0000, rx[0])
        pulse_sync(0);
        `CHK("unsettled", 1'b0, data_settled)
        repeat (700) @(negedge sys_clk);
        `CHK("still unsettled", 1'b0, data_settled)
        repeat (100) @(negedge sys_clk);
        `CHK("settled", 1'b1, data_settled)
        pulse_sync(253);
        `CHK("aligned sync kept", 1'b1, data_settled)
        frame('{16'h6300, 16'h0700}, 8);
        pulse_sync(253);
        `CHK("chop restart", 1'b0, data_settled)
        give_verdict();
    end
endmodule : adc_register_access_and_sync_tb_top
